/* mcs_field_model.sv */
// Behavioural CAN controller and RS485 link partner
`timescale 1ns/100ps
`default_nettype none
module mcs_field_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Behaviour set by the bench
   input wire logic slow,
   input wire logic [15:0] present,
   // CAN controller side
   input wire logic tx_valid,
   output logic tx_ready,
   // RS485 link side
   input wire logic poll_valid,
   input wire logic [3:0] poll_addr,
   output logic poll_ready,
   output logic res_valid,
   output logic res_answered
);
   integer seed = 32'h2059; // Fixed seed for stalls
   logic pend; // Poll in flight
   logic [3:0] addr_q; // Address being polled
   logic [1:0] wait_q; // Remaining answer delay
   // Controller stalls at random when slow, so held offers get exercised
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_ready <= 1'b0;
      else
         tx_ready <= tx_valid && (!slow || $random(seed) % 2 != 0);
   end
   // One poll outstanding; only a node present at that address answers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         poll_ready <= 1'b0;
         res_valid <= 1'b0;
         res_answered <= 1'b0;
         pend <= 1'b0;
         addr_q <= 4'h0;
         wait_q <= 2'h0;
      end
      else
      begin
         res_valid <= 1'b0;
         res_answered <= ~res_answered; // Meaningless outside a result
         if (poll_valid && poll_ready)
         begin
            poll_ready <= 1'b0;
            pend <= 1'b1;
            addr_q <= poll_addr;
            wait_q <= slow ? 2'h3 : 2'h0;
         end
         else if (pend && wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
         else if (pend)
         begin
            pend <= 1'b0;
            res_valid <= 1'b1;
            res_answered <= present[addr_q];
         end
         else
            poll_ready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* mcs_node_supervisor.sv */
// RS485 node discovery and drop supervision
`timescale 1ns/100ps
`default_nettype none
module mcs_node_supervisor
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Poll request to the link
   output logic poll_valid_q,
   output logic [3:0] poll_addr_q,
   input wire logic poll_ready,
   // Poll result from the link
   input wire logic result_valid,
   input wire logic result_answered,
   // State
   output logic [15:0] found_q,
   output logic [15:0] active_q,
   output logic scanning_q
);
   // ==========================================
   // State
   typedef enum logic [1:0] {
      SCAN_REQ = 2'b00,
      SCAN_WAIT = 2'b01,
      RUN_REQ = 2'b10,
      RUN_WAIT = 2'b11
   } mcs_node_state_type;
   mcs_node_state_type state_q;
   logic [1:0] miss_q [16]; // Consecutive misses per node
   wire take = poll_valid_q & poll_ready;
   wire answered = result_valid & result_answered;
   wire missed = result_valid & ~result_answered;
   wire last_addr = poll_addr_q == 4'hf;

   // ==========================================
   // Sequencer: scan all 16 addresses once, then poll live nodes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= SCAN_REQ;
         poll_valid_q <= 1'b0;
         poll_addr_q <= 4'h0;
         found_q <= 16'h0000;
         active_q <= 16'h0000;
         scanning_q <= 1'b1;
         for (int i = 0; i < 16; i++)
            miss_q[i] <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            SCAN_REQ, RUN_REQ:
            begin
               if (take)
               begin
                  // Request accepted, wait for its result
                  poll_valid_q <= 1'b0;
                  state_q <= (state_q == SCAN_REQ) ? SCAN_WAIT : RUN_WAIT;
               end
               else if (state_q == SCAN_REQ || active_q[poll_addr_q])
                  poll_valid_q <= 1'b1;
               else
                  poll_addr_q <= poll_addr_q + 4'h1; // Dropped or absent: skip
            end
            SCAN_WAIT:
            begin
               if (result_valid)
               begin
                  found_q[poll_addr_q] <= result_answered;
                  active_q[poll_addr_q] <= result_answered;
                  poll_addr_q <= poll_addr_q + 4'h1;
                  scanning_q <= ~last_addr;
                  state_q <= last_addr ? RUN_REQ : SCAN_REQ;
               end
            end
            RUN_WAIT:
            begin
               if (answered)
                  miss_q[poll_addr_q] <= 2'h0;
               else if (missed)
               begin
                  miss_q[poll_addr_q] <= miss_q[poll_addr_q] + 2'h1;
                  // A node silent for several polls leaves service
                  if (miss_q[poll_addr_q] == 2'(mcs_pkg::MISS_LIMIT - 1))
                     active_q[poll_addr_q] <= 1'b0;
               end
               if (result_valid)
               begin
                  poll_addr_q <= poll_addr_q + 4'h1;
                  state_q <= RUN_REQ;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* mcs_pkg.sv */
// Shared constants and carriers of the motion card supervisor
package mcs_pkg;
   // ==========================================
   // Clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int US_CYC = CLK_HZ / 1_000_000;
   localparam int CAN_BPS = 1_000_000;
   localparam int CAN_BIT_CYC = CLK_HZ / CAN_BPS;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam int MISS_LIMIT = 3;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] WDOG_IVL_OFF = 8'h04;
   localparam logic [7:0] SERVICE_OFF = 8'h08;
   localparam logic [7:0] SWITCH_N_OFF = 8'h0c;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] NODES_OFF = 8'h14;
   localparam logic [2:0] POS_CMD_BLK = 3'h1;
   localparam logic [2:0] POS_FB_BLK = 3'h2;
   // ==========================================
   // Field positions and reset values
   localparam int CTRL_WDOG_EN = 0;
   localparam int CTRL_PWR_REQ = 1;
   localparam int CTRL_HOST_RUN = 2;
   localparam int CTRL_HOST_ERR = 3;
   localparam int CTRL_LINK_EN = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] WDOG_IVL_RST = 32'h0000_0bb8;
   // ==========================================
   // Servo link identifiers
   localparam int AXES = 6;
   localparam logic [10:0] CMD_ID_BASE = 11'h010;
   localparam logic [10:0] FB_ID_BASE = 11'h020;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic [10:0] id;
      logic [31:0] data;
   } mcs_frame_type;
   typedef struct packed {
      logic [1:0] estop;
      logic [5:0] upper;
      logic [5:0] lower;
      logic [5:0] home;
   } mcs_switch_type;
endpackage

/* mcs_supervisor_properties.sv */
// Port-level assertions for the motion card supervisor top
`timescale 1ns/100ps
`default_nettype none
module mcs_supervisor_properties
#(
   parameter int BLINK_HALF_CYCLES = 8
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Servo link frame port
   input wire logic CAN_TX_VALID,
   input wire mcs_pkg::mcs_frame_type CAN_TX_FRAME,
   input wire logic CAN_TX_READY,
   input wire logic CAN_BUF_FULL,
   input wire logic CAN_BIT_TICK,
   // Node poll port
   input wire logic NODE_POLL_VALID,
   input wire logic [3:0] NODE_POLL_ADDR,
   input wire logic NODE_POLL_READY,
   // Power and lamps
   input wire logic POWER_FAULT,
   input wire logic [5:0] POWER_ENABLE,
   input wire logic CAN_LAMP,
   input wire logic BOOT_LAMP
);
   // ==========
   // Common timing
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Nine quiet cycles, then the next bit tick
   sequence s_bit_gap;
      (!CAN_BIT_TICK) [*8] ##1 !CAN_BIT_TICK ##1 CAN_BIT_TICK;
   endsequence
   // Offer still up and frame untouched
   sequence s_frame_held;
      CAN_TX_VALID && $stable(CAN_TX_FRAME);
   endsequence
   // ==========
   // Checks
   a_bit_tick_period: assert property (CAN_BIT_TICK |=> s_bit_gap)
      else $error("bit tick spacing wrong");
   a_frame_hold_offer: assert property (CAN_TX_VALID && !CAN_TX_READY |=> s_frame_held)
      else $error("frame changed before taken");
   a_cmd_id_range: assert property (CAN_TX_VALID |-> CAN_TX_FRAME.id inside {[11'h010:11'h015]})
      else $error("command id out of range");
   a_power_all_same: assert property (POWER_ENABLE == 6'h00 || POWER_ENABLE == 6'h3f)
      else $error("power enables differ");
   a_fault_power_off: assert property (POWER_FAULT [*5] |-> POWER_ENABLE == 6'h00)
      else $error("power on during fault");
   a_poll_addr_hold: assert property (NODE_POLL_VALID && !NODE_POLL_READY |=> NODE_POLL_VALID
      && $stable(NODE_POLL_ADDR))
      else $error("poll dropped or address moved");
   a_full_lamp_lit: assert property (CAN_BUF_FULL [*3] |-> CAN_LAMP)
      else $error("lamp dark with full buffer");
   a_boot_lamp_stays: assert property (BOOT_LAMP |=> BOOT_LAMP)
      else $error("boot lamp went dark");
endmodule
bind mcs_supervisor_top mcs_supervisor_properties #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) chk_u (.CLK(CLK),
   .RST_N(RST_N), .CAN_TX_VALID(CAN_TX_VALID), .CAN_TX_FRAME(CAN_TX_FRAME), .CAN_TX_READY(CAN_TX_READY),
   .CAN_BUF_FULL(CAN_BUF_FULL), .CAN_BIT_TICK(CAN_BIT_TICK), .NODE_POLL_VALID(NODE_POLL_VALID),
   .NODE_POLL_ADDR(NODE_POLL_ADDR), .NODE_POLL_READY(NODE_POLL_READY), .POWER_FAULT(POWER_FAULT),
   .POWER_ENABLE(POWER_ENABLE), .CAN_LAMP(CAN_LAMP), .BOOT_LAMP(BOOT_LAMP));
`default_nettype wire

/* mcs_supervisor_top.sv */
// Motion card supervisor: watchdog, servo link frames, nodes, switches and lamps
`timescale 1ns/100ps
`default_nettype none
module mcs_supervisor_top
#(
   parameter int BLINK_HALF_CYCLES = mcs_pkg::BLINK_HALF_CYC
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // Servo link frame port to the CAN controller
   output logic CAN_TX_VALID,
   output var mcs_pkg::mcs_frame_type CAN_TX_FRAME,
   input wire logic CAN_TX_READY,
   input wire logic CAN_RX_VALID,
   input wire mcs_pkg::mcs_frame_type CAN_RX_FRAME,
   input wire logic CAN_BUF_FULL,
   output logic CAN_BIT_TICK,
   // RS485 poll port
   output logic NODE_POLL_VALID,
   output logic [3:0] NODE_POLL_ADDR,
   input wire logic NODE_POLL_READY,
   input wire logic NODE_RESULT_VALID,
   input wire logic NODE_RESULT_ANSWERED,
   // Field pins
   input wire mcs_pkg::mcs_switch_type SWITCH_PINS,
   input wire logic POWER_FAULT,
   output logic [5:0] POWER_ENABLE,
   // Lamps
   output logic CAN_LAMP,
   output logic NODE_LAMP,
   output logic FAULT_LAMP,
   output logic BOOT_LAMP,
   output logic HOST_RUN_LAMP
);
   // ==========================================
   // Declarations
   localparam int AX = mcs_pkg::AXES;
   logic [31:0] ctrl_q; // Control word
   logic [31:0] ivl_q; // Watchdog interval in microseconds
   logic [31:0] wd_cnt_q; // Elapsed microseconds since service
   logic [3:0] us_cnt_q; // Microsecond divider
   logic expired_q; // Latched watchdog expiry
   logic [5:0] pwr_q; // Drive power enables
   logic [19:0] sw_meta_q; // First synchroniser stage
   logic [19:0] sw_sync_q; // Second synchroniser stage
   logic [1:0] flt_sync_q; // Power fault synchroniser
   mcs_pkg::mcs_switch_type sample_q; // Switches caught at service
   logic [31:0] pos_cmd_q [AX]; // Commanded positions
   logic [31:0] pos_fb_q [AX]; // Measured positions
   logic [5:0] pend_q; // Axes with a frame waiting
   logic tx_valid_q;
   mcs_pkg::mcs_frame_type tx_frame_q;
   logic [3:0] bit_cnt_q; // Bit-time divider
   logic bit_tick_q;
   logic wr_pend_q; // AHB write data phase pending
   logic [7:0] wr_addr_q;
   logic [31:0] rdata_q;
   logic [21:0] blink_cnt_q; // Lamp blink divider
   logic blink_q; // Blink phase
   logic traffic_seen_q; // Traffic since last blink toggle
   logic traffic_q; // Traffic in last blink phase
   logic [4:0] lamp_q; // Registered lamp levels
   logic [15:0] found;
   logic [15:0] active;
   logic scanning;

   // ==========================================
   // Bus decode
   wire addr_phase = HSEL & HREADY & HTRANS[1];
   wire [7:0] a = HADDR[7:0];
   wire svc_read = addr_phase & ~HWRITE & (a == mcs_pkg::SERVICE_OFF);
   wire [2:0] wr_ax = wr_addr_q[4:2];
   wire wr_pos = wr_pend_q & (wr_addr_q[7:5] == mcs_pkg::POS_CMD_BLK) & (wr_ax < 3'(AX));
   wire [2:0] rd_ax = a[4:2];
   wire rd_ax_ok = rd_ax < 3'(AX);
   wire [5:0] link_en = ctrl_q[mcs_pkg::CTRL_LINK_EN +: 6];
   wire wd_en = ctrl_q[mcs_pkg::CTRL_WDOG_EN];
   wire us_tick = us_cnt_q == 4'(mcs_pkg::US_CYC - 1);
   wire blink_tog = blink_cnt_q == 22'(BLINK_HALF_CYCLES - 1);
   wire [31:0] status_w = {26'h0, CAN_BUF_FULL, scanning, flt_sync_q[1], |pwr_q, expired_q, 1'b0};

   // Read selection; the service register reads the live sample being latched
   function automatic logic [31:0] read_word(input logic [7:0] ad);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (ad)
         mcs_pkg::CTRL_OFF: r = ctrl_q;
         mcs_pkg::WDOG_IVL_OFF: r = ivl_q;
         mcs_pkg::SERVICE_OFF: r = {12'h0, sw_sync_q};
         mcs_pkg::SWITCH_N_OFF: r = {12'h0, ~sample_q};
         mcs_pkg::STATUS_OFF: r = status_w;
         mcs_pkg::NODES_OFF: r = {found, active};
         default: r = 32'h0000_0000;
      endcase
      if (ad[7:5] == mcs_pkg::POS_CMD_BLK && rd_ax_ok)
         r = pos_cmd_q[rd_ax];
      if (ad[7:5] == mcs_pkg::POS_FB_BLK && rd_ax_ok)
         r = pos_fb_q[rd_ax];
      return r;
   endfunction

   // Lowest pending axis wins the next frame slot
   function automatic logic [2:0] first_axis(input logic [5:0] m);
      logic [2:0] k;
      k = 3'h0;
      for (int i = AX - 1; i >= 0; i--)
         if (m[i])
            k = 3'(i);
      return k;
   endfunction

   // ==========================================
   // AHB-Lite slave: zero wait, always OKAY
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
         HREADYOUT <= 1'b0;
      end
      else
      begin
         HREADYOUT <= 1'b1;
         wr_pend_q <= addr_phase & HWRITE;
         if (addr_phase)
            wr_addr_q <= a;
         // Read data lands in the data phase
         if (addr_phase & ~HWRITE)
            rdata_q <= read_word(a);
      end
   end
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;

   // ==========================================
   // Software-written registers
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ctrl_q <= mcs_pkg::CTRL_RST;
         ivl_q <= mcs_pkg::WDOG_IVL_RST;
      end
      else if (wr_pend_q)
      begin
         if (wr_addr_q == mcs_pkg::CTRL_OFF)
            ctrl_q <= HWDATA & 32'h0000_3f0f;
         if (wr_addr_q == mcs_pkg::WDOG_IVL_OFF)
            ivl_q <= HWDATA;
      end
   end

   // ==========================================
   // Pin synchronisers and service sampling
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sw_meta_q <= 20'h00000;
         sw_sync_q <= 20'h00000;
         flt_sync_q <= 2'h0;
         sample_q <= '0;
      end
      else
      begin
         sw_meta_q <= SWITCH_PINS;
         sw_sync_q <= sw_meta_q;
         flt_sync_q <= {flt_sync_q[0], POWER_FAULT};
         // Host sees a snapshot, not a moving level
         if (svc_read)
            sample_q <= sw_sync_q;
      end
   end

   // ==========================================
   // Watchdog on a microsecond tick
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         us_cnt_q <= 4'h0;
         wd_cnt_q <= 32'h0000_0000;
         expired_q <= 1'b0;
      end
      else
      begin
         us_cnt_q <= us_tick ? 4'h0 : us_cnt_q + 4'h1;
         if (!wd_en)
         begin
            // Disabling is the only way out of expiry
            wd_cnt_q <= 32'h0000_0000;
            expired_q <= 1'b0;
         end
         else if (svc_read)
            wd_cnt_q <= 32'h0000_0000;
         else if (us_tick && !expired_q)
         begin
            if (wd_cnt_q + 32'h1 >= ivl_q)
               expired_q <= 1'b1;
            wd_cnt_q <= wd_cnt_q + 32'h1;
         end
      end
   end

   // ==========================================
   // Drive power enables, cut in the expiry cycle itself
   wire expire_now = wd_en & ~svc_read & us_tick & ~expired_q & (wd_cnt_q + 32'h1 >= ivl_q);
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         pwr_q <= 6'h00;
      else
         pwr_q <= {6{ctrl_q[mcs_pkg::CTRL_PWR_REQ] & ~expired_q & ~expire_now & ~flt_sync_q[1]}};
   end
   assign POWER_ENABLE = pwr_q;

   // ==========================================
   // Position commands and feedback storage
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < AX; i++)
         begin
            pos_cmd_q[i] <= 32'h0000_0000;
            pos_fb_q[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         if (wr_pos)
            pos_cmd_q[wr_ax] <= HWDATA;
         // Only the six feedback ids are accepted
         for (int i = 0; i < AX; i++)
            if (CAN_RX_VALID && CAN_RX_FRAME.id == mcs_pkg::FB_ID_BASE + 11'(i))
               pos_fb_q[i] <= CAN_RX_FRAME.data;
      end
   end

   // ==========================================
   // Frame scheduler toward the CAN controller
   wire tx_take = tx_valid_q & CAN_TX_READY;
   wire tx_free = ~tx_valid_q | CAN_TX_READY;
   wire [2:0] nx = first_axis(pend_q);
   wire load = tx_free & (|pend_q);
   wire [5:0] pend_set = (wr_pos & link_en[wr_ax]) ? 6'(6'h01 << wr_ax) : 6'h00;
   wire [5:0] pend_clr = load ? 6'(6'h01 << nx) : 6'h00;
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pend_q <= 6'h00;
         tx_valid_q <= 1'b0;
         tx_frame_q <= '0;
      end
      else
      begin
         // A new write on the axis being sent stays pending
         pend_q <= ((pend_q & ~pend_clr) | pend_set) & link_en;
         if (load)
         begin
            tx_valid_q <= 1'b1;
            tx_frame_q <= '{id: mcs_pkg::CMD_ID_BASE + 11'(nx), data: pos_cmd_q[nx]};
         end
         else if (tx_take)
            tx_valid_q <= 1'b0;
      end
   end
   assign CAN_TX_VALID = tx_valid_q;
   assign CAN_TX_FRAME = tx_frame_q;

   // ==========================================
   // Bit-time enable for the controller
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         bit_cnt_q <= 4'h0;
         bit_tick_q <= 1'b0;
      end
      else
      begin
         bit_tick_q <= bit_cnt_q == 4'(mcs_pkg::CAN_BIT_CYC - 1);
         bit_cnt_q <= (bit_cnt_q == 4'(mcs_pkg::CAN_BIT_CYC - 1)) ? 4'h0 : bit_cnt_q + 4'h1;
      end
   end
   assign CAN_BIT_TICK = bit_tick_q;
   // ==========================================
   // RS485 node supervision
   mcs_node_supervisor u_nodes
   (
      .clk(CLK),
      .rst_n(RST_N),
      .poll_valid_q(NODE_POLL_VALID),
      .poll_addr_q(NODE_POLL_ADDR),
      .poll_ready(NODE_POLL_READY),
      .result_valid(NODE_RESULT_VALID),
      .result_answered(NODE_RESULT_ANSWERED),
      .found_q(found),
      .active_q(active),
      .scanning_q(scanning)
   );

   // ==========================================
   // Blink divider and traffic memory
   wire traffic = tx_take | CAN_RX_VALID;
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         blink_cnt_q <= 22'h000000;
         blink_q <= 1'b0;
         traffic_seen_q <= 1'b0;
         traffic_q <= 1'b0;
      end
      else
      begin
         blink_cnt_q <= blink_tog ? 22'h000000 : blink_cnt_q + 22'h000001;
         if (blink_tog)
         begin
            blink_q <= ~blink_q;
            traffic_q <= traffic_seen_q | traffic;
            traffic_seen_q <= traffic; // Set wins over the phase clear
         end
         else if (traffic)
            traffic_seen_q <= 1'b1;
      end
   end

   // ==========================================
   // Lamps
   wire can_l = CAN_BUF_FULL | (traffic_q & blink_q);
   wire node_l = scanning ? blink_q : (found == active);
   wire flt_l = expired_q | (ctrl_q[mcs_pkg::CTRL_HOST_ERR] & blink_q);
   wire boot_l = ~scanning;
   wire host_l = ctrl_q[mcs_pkg::CTRL_HOST_RUN] & blink_q;
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         lamp_q <= 5'h00;
      else
         lamp_q <= {can_l, node_l, flt_l, boot_l, host_l};
   end
   assign CAN_LAMP = lamp_q[4];
   assign NODE_LAMP = lamp_q[3];
   assign FAULT_LAMP = lamp_q[2];
   assign BOOT_LAMP = lamp_q[1];
   assign HOST_RUN_LAMP = lamp_q[0];
endmodule
`default_nettype wire

/* tb_mcs_supervisor_top.sv */
// Self-checking bench for the motion card supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_mcs_supervisor_top;
   // ==========
   // Signals
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic CAN_RX_VALID = 1'b0;
   logic CAN_BUF_FULL = 1'b0;
   logic POWER_FAULT = 1'b0;
   logic slow = 1'b1;
   logic [15:0] present = 16'h0;
   logic HREADYOUT, HRESP, CAN_TX_VALID, CAN_TX_READY, CAN_BIT_TICK, POLL_VALID, POLL_READY, RES_VALID, RES_ANS;
   logic [3:0] POLL_ADDR;
   logic [31:0] HRDATA;
   logic [5:0] POWER_ENABLE;
   logic [4:0] lamps; // {host, boot, fault, node, can}
   mcs_pkg::mcs_frame_type CAN_TX_FRAME;
   mcs_pkg::mcs_frame_type CAN_RX_FRAME = '0;
   mcs_pkg::mcs_switch_type SWITCH_PINS = '0;
   integer seed = 32'h2059;
   int miscompares = 0;
   int num_checks = 0;
   logic [63:0] exp_q [$]; // Frames the model expects, in order
   logic [63:0] exp_f;
   logic [31:0] d [6];
   logic [31:0] w;
   logic [19:0] sw;
   logic [15:0] pres0;
   always #50 CLK = ~CLK;
   mcs_supervisor_top #(.BLINK_HALF_CYCLES(8)) dut_u (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .HRDATA(HRDATA), .CAN_TX_VALID(CAN_TX_VALID), .CAN_TX_FRAME(CAN_TX_FRAME),
      .CAN_TX_READY(CAN_TX_READY), .CAN_RX_VALID(CAN_RX_VALID), .CAN_RX_FRAME(CAN_RX_FRAME),
      .CAN_BUF_FULL(CAN_BUF_FULL), .CAN_BIT_TICK(CAN_BIT_TICK), .NODE_POLL_VALID(POLL_VALID),
      .NODE_POLL_ADDR(POLL_ADDR), .NODE_POLL_READY(POLL_READY), .NODE_RESULT_VALID(RES_VALID),
      .NODE_RESULT_ANSWERED(RES_ANS), .SWITCH_PINS(SWITCH_PINS), .POWER_FAULT(POWER_FAULT),
      .POWER_ENABLE(POWER_ENABLE), .CAN_LAMP(lamps[0]), .NODE_LAMP(lamps[1]), .FAULT_LAMP(lamps[2]),
      .BOOT_LAMP(lamps[3]), .HOST_RUN_LAMP(lamps[4]));
   mcs_field_model far_u (.clk(CLK), .rst_n(RST_N), .slow(slow), .present(present), .tx_valid(CAN_TX_VALID),
      .tx_ready(CAN_TX_READY), .poll_valid(POLL_VALID), .poll_addr(POLL_ADDR), .poll_ready(POLL_READY),
      .res_valid(RES_VALID), .res_answered(RES_ANS));
   // ==========
   // Tasks
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic stuck;
      miscompares++;
      final_report;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1)
      begin
         n++;
         if (n > 50)
            stuck;
         @(posedge CLK);
      end
   endtask
   // One single transfer; read data is taken at the data phase edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      wait_rdy;
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      wait_rdy;
      w = HRDATA;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(64'({HRESP, w}), 64'({1'b0, e}));
   endtask
   // Lamp verdict over six blink halves: 0 dark, 1 lit, 2 blinking
   task automatic lamp(input int i, input logic [1:0] e);
      int ones;
      int tg;
      logic prev;
      ones = 0;
      tg = 0;
      repeat (2) @(posedge CLK);
      prev = lamps[i];
      repeat (48)
      begin
         @(posedge CLK);
         ones += lamps[i];
         tg += (lamps[i] != prev);
         prev = lamps[i];
      end
      chk(64'(tg > 1 ? 2 : ones == 48 ? 1 : ones == 0 ? 0 : 3), 64'(e));
   endtask
   task automatic wait_until(input int i, input logic v);
      int n;
      n = 0;
      while (lamps[i] !== v)
      begin
         n++;
         if (n > 3000)
            stuck;
         @(posedge CLK);
      end
   endtask
   // Every frame taken is compared with the oldest expected one
   always @(posedge CLK)
   begin
      if (CAN_TX_VALID === 1'b1 && CAN_TX_READY === 1'b1)
      begin
         exp_f = exp_q.size() > 0 ? exp_q.pop_front() : 64'h0;
         chk(64'(CAN_TX_FRAME), exp_f);
      end
   end
   // ==========
   // Main sequence
   initial
   begin
      for (int k = 0; k < 6; k++)
         d[k] = $random(seed);
      present = 16'($random(seed)) | 16'h8001;
      pres0 = present;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      lamp(1, 2'h2);
      chk(64'(lamps[3]), 64'h0);
      wait_until(3, 1'b1);
      rd(mcs_pkg::NODES_OFF, {pres0, pres0});
      lamp(1, 2'h1);
      present[0] <= 1'b0;
      wait_until(1, 1'b0);
      rd(mcs_pkg::NODES_OFF, {pres0, pres0 & 16'hfffe});
      rd(mcs_pkg::CTRL_OFF, 32'h0);
      rd(mcs_pkg::WDOG_IVL_OFF, 32'h0000_0bb8);
      rd(8'h7c, 32'h0);
      // Axis 2 link disabled: its command must never appear
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'h0000_3b00);
      for (int k = 0; k < 6; k++)
      begin
         if (k != 2)
            exp_q.push_back(64'({mcs_pkg::CMD_ID_BASE + 11'(k), d[k]}));
         xfer(1'b1, 8'h20 + 8'(4 * k), d[k]);
      end
      for (int n = 0; exp_q.size() > 0; n++)
      begin
         if (n > 500)
            stuck;
         @(posedge CLK);
      end
      fork
         lamp(0, 2'h2);
         for (int k = 0; k < 10; k++)
         begin
            w = k < 6 ? d[k] ^ 32'h0f0f_0f0f : 32'($random(seed));
            CAN_RX_VALID <= 1'b1;
            CAN_RX_FRAME <= {11'(k < 8 ? 'h20 + k : 'h16 + k), w};
            @(posedge CLK);
            CAN_RX_VALID <= 1'b0;
            CAN_RX_FRAME <= ~CAN_RX_FRAME;
            repeat (3) @(posedge CLK);
         end
      join
      for (int k = 0; k < 6; k++)
         rd(8'h40 + 8'(4 * k), d[k] ^ 32'h0f0f_0f0f);
      repeat (20) @(posedge CLK);
      lamp(0, 2'h0);
      CAN_BUF_FULL <= 1'b1;
      lamp(0, 2'h1);
      CAN_BUF_FULL <= 1'b0;
      sw = 20'($random(seed));
      SWITCH_PINS <= sw;
      repeat (4) @(posedge CLK);
      rd(mcs_pkg::SERVICE_OFF, {12'h0, sw});
      SWITCH_PINS <= ~sw;
      repeat (4) @(posedge CLK);
      rd(mcs_pkg::SWITCH_N_OFF, {12'h0, ~sw});
      xfer(1'b1, mcs_pkg::WDOG_IVL_OFF, 32'h5);
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'h2);
      repeat (100) @(posedge CLK);
      chk(64'(POWER_ENABLE), 64'h3f);
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'h3);
      repeat (10)
      begin
         repeat (20) @(posedge CLK);
         xfer(1'b0, mcs_pkg::SERVICE_OFF, 32'h0);
      end
      chk(64'(POWER_ENABLE), 64'h3f);
      repeat (80) @(posedge CLK);
      chk(64'(POWER_ENABLE), 64'h0);
      rd(mcs_pkg::STATUS_OFF, 32'h2);
      lamp(2, 2'h1);
      rd(mcs_pkg::STATUS_OFF, 32'h2);
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'h2);
      repeat (2) @(posedge CLK);
      rd(mcs_pkg::STATUS_OFF, 32'h4);
      POWER_FAULT <= 1'b1;
      repeat (5) @(posedge CLK);
      rd(mcs_pkg::STATUS_OFF, 32'h8);
      POWER_FAULT <= 1'b0;
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'hc);
      lamp(4, 2'h2);
      lamp(2, 2'h2);
      xfer(1'b1, mcs_pkg::CTRL_OFF, 32'h0);
      lamp(4, 2'h0);
      lamp(2, 2'h0);
      final_report;
   end
endmodule
`default_nettype wire
